// file: logic/lrd_pkg.sv
// Constants and types of the link relay and retained data block
`default_nettype none
package lrd_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SCAN_STEP_US = 100;
  localparam int unsigned SCAN_STEP_CYC = SCAN_STEP_US * CLK_MHZ;
  localparam logic [2:0] LINK_GAP_CYC = 3'h7;
  // ==========================================================
  // Register word addresses
  localparam logic [7:0] A_LINK_FLAGS = 8'h03;
  localparam logic [7:0] A_RET_CTRL = 8'h05;
  localparam logic [7:0] A_SCAN = 8'h07;
  localparam logic [7:0] A_ANALOG_TIMER_ONE = 8'h08;
  localparam logic [7:0] A_ANALOG_TIMER_TWO = 8'h09;
  localparam logic [7:0] A_CONFIG = 8'h0A;
  localparam logic [7:0] A_CMD = 8'h0B;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [3:0] A_DR_PAGE = 4'h1;
  // ==========================================================
  // Field positions
  localparam int unsigned RET_BIT = 15;
  localparam int unsigned CFG_RUN_BIT = 0;
  localparam int unsigned CFG_SIZE_LSB = 1;
  localparam int unsigned CMD_SAVE = 0;
  localparam int unsigned CMD_CLEAR = 1;
  localparam int unsigned CMD_PSTART = 2;
  localparam int unsigned CMD_PXFER = 3;
  localparam int unsigned CMD_ERRCLR = 4;
  // ==========================================================
  // Sizes and reset values
  localparam logic [4:0] DR_WORDS = 5'h10;
  localparam logic [4:0] LR_64_WORDS = 5'h04;
  localparam logic [4:0] LR_128_WORDS = 5'h08;
  localparam logic [7:0] BCD_MAX = 8'h99;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LR_NONE = 2'h0, LR_64 = 2'h1, LR_128 = 2'h2
  } lrd_size_e;
  typedef enum logic [2:0] {
    ST_BOOT0 = 3'h0, ST_BOOT1 = 3'h1, ST_LOAD = 3'h3,
    ST_IDLE = 3'h2, ST_SAVE = 3'h6
  } lrd_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } lrd_bus_s;
  typedef struct packed {
    logic [15:0] data;
    logic [2:0] idx;
    logic [1:0] station;
    logic tgl;
  } lrd_link_s;
  typedef struct packed {
    lrd_state_e st;
    logic [15:0][15:0] dr;
    logic [4:0] cnt;
    logic ret;
    logic run;
    lrd_size_e size;
    logic prog_started;
    logic size_changed;
    logic xfer_err;
    logic size_err;
    logic prog_ok;
    logic [15:0] tick;
    logic [7:0] scan_acc;
    logic [7:0] scan_cur;
    logic [7:0] scan_max;
    logic [7:0] analog_timer_one_s1;
    logic [7:0] analog_timer_one_s2;
    logic [7:0] analog_timer_two_s1;
    logic [7:0] analog_timer_two_s2;
    logic nv_s1;
    logic nv_s2;
    logic [1:0] stn_s1;
    logic [1:0] stn_s2;
    logic [1:0] stn;
    logic [3:0] err_s1;
    logic [3:0] err_s2;
    lrd_link_s rx_s1;
    lrd_link_s rx_s2;
    logic rx_prev;
    logic [2:0] gap;
    logic tx_half;
    lrd_link_s tx;
    logic [3:0] nv_addr;
    logic nv_we;
    logic [15:0] nv_wdata;
    logic [15:0] rdata;
    logic [7:0] flags;
  } lrd_regs_s;
endpackage : lrd_pkg
`default_nettype wire

// file: logic/lrd_top.sv
// Link relay area, retained data area and monitor words
//
// Contract
// - Retained enable set at power-up copies nonvolatile words into working memory.
// - Finishing the retentive save operation leaves the retained enable set.
// - Retained enable survives power loss and triggers the copy next power-on.
// - Data clear drops retained enable; software may force it off.
// - Low byte of scan word holds longest scan, BCD 0.0 to 9.9 ms.
// - Longest scan field clears whenever operation begins.
// - High byte of scan word holds latest scan, BCD in 0.1 ms.
// - Word 08 shows first analog timer setting in BCD.
// - Word 09 shows second analog timer setting in BCD.
// - Link storage taken from retentive area in 64 or 128 bit segments.
// - Zero link size disables link area; nothing exchanged.
// - 64-bit size gives one write word per station; retentive words 00-11.
// - 128-bit size gives two write words per station; retentive words 00-07.
// - Each station writes only its own link write words.
// - All stations and console use one identical link size.
// - Own link words propagate to the same words of every peer.
// - Station zero owns link word 00; others read it.
// - Link size changes only in program mode, applying to all stations.
// - Link size readable in run and program mode.
// - Size change after programming began or illegal address refuses transfer.
// - Retained data lives in retentive area sized by link allocation.
// - Per-station link error flags raise on link errors.
// - Per-station link-normal flag while healthy; own station's flag also held in run mode.
`timescale 1ns/1ps
`default_nettype none
module lrd_top
  import lrd_pkg::*;
#(
  parameter int unsigned SCAN_STEP = SCAN_STEP_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire lrd_bus_s bus,
  output logic [15:0] rdata,
  input wire logic scan_end,
  input wire logic prog_illegal,
  input wire logic [7:0] analog_timer_one_raw,
  input wire logic [7:0] analog_timer_two_raw,
  input wire logic [1:0] station_pin,
  input wire logic nv_flag_in,
  input wire logic [15:0] nv_rdata,
  output logic [3:0] nv_addr,
  output logic nv_we,
  output logic [15:0] nv_wdata,
  output logic nv_flag_out,
  input wire lrd_link_s link_rx,
  input wire logic [3:0] link_err,
  output lrd_link_s link_tx,
  output logic [7:0] link_flags
);

  // ==========================================================
  // Helpers
  function automatic logic [4:0] lr_words(input lrd_size_e s);
    logic [4:0] n;
    n = 5'h00;
    if (s == LR_64) begin
      n = LR_64_WORDS;
    end else if (s == LR_128) begin
      n = LR_128_WORDS;
    end
    return n;
  endfunction : lr_words

  function automatic logic owns(input lrd_size_e s,
                                input logic [1:0] st,
                                input logic [2:0] idx);
    logic o;
    o = 1'b0;
    if (s == LR_64) begin
      o = (idx == {1'b0, st});
    end else if (s == LR_128) begin
      o = (idx[2:1] == st);
    end
    return o;
  endfunction : owns

  function automatic logic [3:0] lr_to_dr(input lrd_size_e s,
                                          input logic [2:0] idx);
    logic [4:0] a;
    a = DR_WORDS - lr_words(s) + {2'h0, idx};
    return a[3:0];
  endfunction : lr_to_dr

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v == BCD_MAX) begin
      r = v;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcd_inc

  function automatic logic [15:0] to_bcd(input logic [7:0] v);
    logic [7:0] c;
    logic [7:0] t;
    logic [7:0] u;
    c = (v > 8'h63) ? 8'h63 : v;
    t = c / 8'h0A;
    u = c - 8'(t * 8'h0A);
    return {8'h00, t[3:0], u[3:0]};
  endfunction : to_bcd

  // ==========================================================
  // State
  lrd_regs_s q_r;
  lrd_regs_s q_nxt;
  logic [4:0] dr_limit;
  logic [4:0] lrw;
  logic dr_hit;
  logic [3:0] dr_idx;
  logic in_lr;
  logic [2:0] lr_idx;
  logic rx_evt;
  lrd_size_e new_size;

  // Usable retentive words shrink with link size
  assign lrw = lr_words(q_r.size);
  assign dr_limit = DR_WORDS - lrw;
  assign dr_hit = (bus.addr[7:4] == A_DR_PAGE);
  assign dr_idx = bus.addr[3:0];
  assign in_lr = ({1'b0, dr_idx} >= dr_limit);
  assign lr_idx = 3'(5'({1'b0, dr_idx}) - dr_limit);
  // Second stage only; first stage feeds nothing else
  assign rx_evt = (q_r.rx_s2.tgl != q_r.rx_prev);
  assign new_size = lrd_size_e'(bus.wdata[CFG_SIZE_LSB +: 2]);

  // ==========================================================
  // Next state
  always_comb begin
    q_nxt = q_r;
    q_nxt.nv_we = 1'b0;
    // Input synchronisers
    q_nxt.analog_timer_one_s1 = analog_timer_one_raw;
    q_nxt.analog_timer_one_s2 = q_r.analog_timer_one_s1;
    q_nxt.analog_timer_two_s1 = analog_timer_two_raw;
    q_nxt.analog_timer_two_s2 = q_r.analog_timer_two_s1;
    q_nxt.nv_s1 = nv_flag_in;
    q_nxt.nv_s2 = q_r.nv_s1;
    q_nxt.stn_s1 = station_pin;
    q_nxt.stn_s2 = q_r.stn_s1;
    q_nxt.err_s1 = link_err;
    q_nxt.err_s2 = q_r.err_s1;
    q_nxt.rx_s1 = link_rx;
    q_nxt.rx_s2 = q_r.rx_s1;
    q_nxt.rx_prev = q_r.rx_s2.tgl;

    // Scan timing in 0.1 ms steps
    if (q_r.tick == 16'(SCAN_STEP - 1)) begin
      q_nxt.tick = 16'h0000;
      q_nxt.scan_acc = bcd_inc(q_r.scan_acc);
    end else begin
      q_nxt.tick = q_r.tick + 16'h0001;
    end
    if (scan_end) begin
      q_nxt.tick = 16'h0000;
      q_nxt.scan_acc = 8'h00;
      q_nxt.scan_cur = q_r.scan_acc;
      // BCD compares like binary when digits are valid
      if (q_r.scan_acc > q_r.scan_max) begin
        q_nxt.scan_max = q_r.scan_acc;
      end
    end

    // Link status flags
    q_nxt.flags[3:0] = q_r.err_s2;
    q_nxt.flags[7:4] = ~q_r.err_s2;
    if (q_r.run) begin
      q_nxt.flags[4 + 32'(q_r.stn)] = 1'b1;
    end

    // Link transmit: own words cycled every few cycles
    if (q_r.st != ST_BOOT0 && q_r.st != ST_BOOT1 &&
        q_r.size != LR_NONE) begin
      if (q_r.gap == 3'h0) begin
        q_nxt.gap = LINK_GAP_CYC;
        if (q_r.size == LR_64) begin
          q_nxt.tx.idx = {1'b0, q_r.stn};
        end else begin
          q_nxt.tx.idx = {q_r.stn, q_r.tx_half};
          q_nxt.tx_half = ~q_r.tx_half;
        end
        q_nxt.tx.station = q_r.stn;
        q_nxt.tx.data = q_r.dr[lr_to_dr(q_r.size, q_nxt.tx.idx)];
        q_nxt.tx.tgl = ~q_r.tx.tgl;
      end else begin
        q_nxt.gap = q_r.gap - 3'h1;
      end
    end

    // Link receive: only peer-owned words of matching layout
    if (rx_evt && q_r.size != LR_NONE &&
        {2'h0, q_r.rx_s2.idx} < lrw &&
        !owns(q_r.size, q_r.stn, q_r.rx_s2.idx) &&
        owns(q_r.size, q_r.rx_s2.station,
             q_r.rx_s2.idx)) begin
      q_nxt.dr[lr_to_dr(q_r.size, q_r.rx_s2.idx)] =
        q_r.rx_s2.data;
    end

    // Register writes
    if (bus.wr) begin
      if (dr_hit) begin
        // Peer words are read-only here to keep one writer
        if (!in_lr || owns(q_r.size, q_r.stn, lr_idx)) begin
          q_nxt.dr[dr_idx] = bus.wdata;
        end
      end
      case (bus.addr)
        A_RET_CTRL: begin
          q_nxt.ret = bus.wdata[RET_BIT];
        end
        A_CONFIG: begin
          q_nxt.run = bus.wdata[CFG_RUN_BIT];
          if (bus.wdata[CFG_RUN_BIT] && !q_r.run) begin
            q_nxt.scan_max = 8'h00;
            q_nxt.scan_acc = 8'h00;
            q_nxt.tick = 16'h0000;
          end
          if (new_size != q_r.size) begin
            if (q_r.run || new_size > LR_128) begin
              q_nxt.size_err = 1'b1;
            end else begin
              q_nxt.size = new_size;
              if (q_r.prog_started) begin
                q_nxt.size_changed = 1'b1;
              end
            end
          end
        end
        A_CMD: begin
          if (bus.wdata[CMD_ERRCLR]) begin
            q_nxt.xfer_err = 1'b0;
            q_nxt.size_err = 1'b0;
            q_nxt.prog_ok = 1'b0;
          end
          if (bus.wdata[CMD_PSTART]) begin
            q_nxt.prog_started = 1'b1;
            q_nxt.size_changed = 1'b0;
          end
          if (bus.wdata[CMD_PXFER]) begin
            if (q_r.size_changed || prog_illegal) begin
              q_nxt.xfer_err = 1'b1;
              q_nxt.prog_ok = 1'b0;
            end else begin
              q_nxt.prog_ok = 1'b1;
            end
          end
          if (q_r.st == ST_IDLE && bus.wdata[CMD_CLEAR]) begin
            q_nxt.dr = '0;
            q_nxt.ret = 1'b0;
          end else if (q_r.st == ST_IDLE && bus.wdata[CMD_SAVE]) begin
            q_nxt.st = ST_SAVE;
            q_nxt.cnt = 5'h00;
          end
        end
        default: begin
        end
      endcase
    end

    // Sequencer
    case (q_r.st)
      ST_BOOT0: begin
        q_nxt.st = ST_BOOT1;
      end
      ST_BOOT1: begin
        // Straps read once synchronisers have settled
        q_nxt.stn = q_r.stn_s2;
        q_nxt.ret = q_r.nv_s2;
        if (q_r.nv_s2) begin
          q_nxt.st = ST_LOAD;
          q_nxt.nv_addr = 4'h0;
          q_nxt.cnt = 5'h00;
        end else begin
          q_nxt.st = ST_IDLE;
        end
      end
      ST_LOAD: begin
        // Read data lags its address by one cycle, so store word cnt-1
        if (q_r.cnt != 5'h00) begin
          q_nxt.dr[4'(q_r.cnt - 5'h01)] = nv_rdata;
        end
        if (q_r.cnt == dr_limit) begin
          q_nxt.st = ST_IDLE;
        end else begin
          q_nxt.nv_addr = 4'(q_r.cnt + 5'h01);
          q_nxt.cnt = q_r.cnt + 5'h01;
        end
      end
      ST_SAVE: begin
        if (q_r.cnt == dr_limit) begin
          q_nxt.st = ST_IDLE;
          q_nxt.ret = 1'b1;
        end else begin
          q_nxt.nv_we = 1'b1;
          q_nxt.nv_addr = q_r.cnt[3:0];
          q_nxt.nv_wdata = q_r.dr[q_r.cnt[3:0]];
          q_nxt.cnt = q_r.cnt + 5'h01;
        end
      end
      ST_IDLE: begin
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase

    // Register reads, data one cycle later
    q_nxt.rdata = RST_WORD;
    if (bus.rd) begin
      if (dr_hit) begin
        q_nxt.rdata = q_r.dr[dr_idx];
      end
      case (bus.addr)
        A_LINK_FLAGS: q_nxt.rdata = {8'h00, q_r.flags};
        A_RET_CTRL: q_nxt.rdata = {q_r.ret, 15'h0000};
        A_SCAN: q_nxt.rdata = {q_r.scan_cur, q_r.scan_max};
        A_ANALOG_TIMER_ONE: q_nxt.rdata = to_bcd(q_r.analog_timer_one_s2);
        A_ANALOG_TIMER_TWO: q_nxt.rdata = to_bcd(q_r.analog_timer_two_s2);
        A_CONFIG: q_nxt.rdata = {13'h0000, q_r.size, q_r.run};
        A_STATUS: begin
          q_nxt.rdata = {10'h000, q_r.size_changed, q_r.prog_started,
                         q_r.prog_ok, q_r.size_err, q_r.xfer_err,
                         q_r.st != ST_IDLE};
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '0;
      q_r.st <= ST_BOOT0;
      q_r.size <= LR_NONE;
      // Synchronisers keep tracking so boot sees settled pins
      q_r.nv_s1 <= nv_flag_in;
      q_r.nv_s2 <= q_r.nv_s1;
      q_r.stn_s1 <= station_pin;
      q_r.stn_s2 <= q_r.stn_s1;
      // No false link edge after reset
      q_r.rx_s1 <= link_rx;
      q_r.rx_s2 <= q_r.rx_s1;
      q_r.rx_prev <= q_r.rx_s2.tgl;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = q_r.rdata;
  assign nv_addr = q_r.nv_addr;
  assign nv_we = q_r.nv_we;
  assign nv_wdata = q_r.nv_wdata;
  assign nv_flag_out = q_r.ret;
  assign link_tx = q_r.tx;
  assign link_flags = q_r.flags;

endmodule : lrd_top
`default_nettype wire

// file: sim/lrd_checker_assertions.sv
// Port assertions of the link relay block
`timescale 1ns/1ps
`default_nettype none
module lrd_checker
  import lrd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire lrd_bus_s bus,
  input wire logic [15:0] rdata,
  input wire logic [1:0] station_pin,
  input wire logic [3:0] nv_addr,
  input wire logic nv_we,
  input wire logic nv_flag_out,
  input wire lrd_link_s link_tx
);
  // ==========================================
  // Read tracking
  logic rd_r;
  logic [7:0] ra_r;
  always_ff @(posedge clk) begin
    rd_r <= bus.rd;
    ra_r <= bus.addr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // Properties
  property p_max_bcd;
    rd_r && ra_r == A_SCAN |-> rdata[3:0] < 4'hA && rdata[7:4] < 4'hA;
  endproperty
  a_max_bcd: assert property (p_max_bcd)
    else $error("max scan not bcd");
  property p_cur_bcd;
    rd_r && ra_r == A_SCAN |-> rdata[11:8] < 4'hA && rdata[15:12] < 4'hA;
  endproperty
  a_cur_bcd: assert property (p_cur_bcd)
    else $error("current scan not bcd");
  property p_analog_timer_one;
    rd_r && ra_r == A_ANALOG_TIMER_ONE |->
      rdata[15:8] == 8'h00 && rdata[7:4] < 4'hA && rdata[3:0] < 4'hA;
  endproperty
  a_analog_timer_one: assert property (p_analog_timer_one)
    else $error("timer one word not bcd");
  property p_analog_timer_two;
    rd_r && ra_r == A_ANALOG_TIMER_TWO |->
      rdata[15:8] == 8'h00 && rdata[7:4] < 4'hA && rdata[3:0] < 4'hA;
  endproperty
  a_analog_timer_two: assert property (p_analog_timer_two)
    else $error("timer two word not bcd");
  property p_clear;
    bus.wr && bus.addr == A_CMD && bus.wdata[CMD_CLEAR] |=> !nv_flag_out;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear kept retained bit");
  property p_save;
    bus.wr && bus.addr == A_CMD && bus.wdata[CMD_SAVE]
      && !bus.wdata[CMD_CLEAR] |-> ##[2:20] nv_flag_out;
  endproperty
  a_save: assert property (p_save)
    else $error("save left retained bit low");
  // Fields must stand so a slow peer still catches the word
  property p_tx_hold;
    $changed(link_tx.tgl) |=> $stable(link_tx) [*6];
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("sent word changed early");
  property p_tx_own;
    $changed(link_tx.tgl) |-> link_tx.station == station_pin;
  endproperty
  a_tx_own: assert property (p_tx_own)
    else $error("sent word under foreign station");
  property p_nv_seq;
    nv_we && nv_addr != 4'h0 |->
      $past(nv_we) && nv_addr == $past(nv_addr) + 4'h1;
  endproperty
  a_nv_seq: assert property (p_nv_seq)
    else $error("save words out of order");
endmodule : lrd_checker
bind lrd_top lrd_checker lrd_checker_i (.clk(clk), .reset(reset),
  .bus(bus), .rdata(rdata), .station_pin(station_pin),
  .nv_addr(nv_addr), .nv_we(nv_we), .nv_flag_out(nv_flag_out),
  .link_tx(link_tx));
`default_nettype wire

// file: sim/lrd_peer.sv
// Behavioural peer controller on the link
`timescale 1ns/1ps
`default_nettype none
module lrd_peer
  import lrd_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] data,
  input wire logic [2:0] idx,
  input wire logic [1:0] stn,
  output var lrd_link_s link_rx
);
  logic [2:0] dly = 3'h0;
  initial link_rx = '0;
  // Sends only the index handed over; fields settle before toggle
  always @(posedge clk) begin
    if (go) begin
      link_rx.data <= data;
      link_rx.idx <= idx;
      link_rx.station <= stn;
      dly <= 3'h4;
    end else if (dly != 3'h0) begin
      dly <= dly - 3'h1;
      if (dly == 3'h1) link_rx.tgl <= ~link_rx.tgl;
    end
  end
endmodule : lrd_peer
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench of the link relay block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lrd_pkg::*;
  logic clk = 1'b0;
  logic reset, ce, scan_end, prog_illegal, nv_we, nv_flag_out, nvf, go;
  lrd_bus_s bus;
  lrd_link_s link_rx, link_tx;
  logic [15:0] rdata, nv_rdata, nv_wdata, pdata, v;
  logic [7:0] analog_timer_one_raw, analog_timer_two_raw, link_flags;
  logic [3:0] nv_addr, link_err;
  logic [2:0] pidx;
  logic [15:0] nvm [16];
  logic [15:0] m [16];
  logic [15:0] w [16];
  int fails = 0, n_compared = 0, cyc = 0, x, up = 0;
  int unsigned seed = 90;
  always #2.5 clk = ~clk;
  lrd_top #(.SCAN_STEP(10)) lrd_top_i (.clk(clk), .reset(reset), .ce(ce),
    .bus(bus), .rdata(rdata), .scan_end(scan_end),
    .prog_illegal(prog_illegal), .analog_timer_one_raw(analog_timer_one_raw),
    .analog_timer_two_raw(analog_timer_two_raw), .station_pin(2'h0), .nv_flag_in(nvf),
    .nv_rdata(nv_rdata), .nv_addr(nv_addr), .nv_we(nv_we),
    .nv_wdata(nv_wdata), .nv_flag_out(nv_flag_out), .link_rx(link_rx),
    .link_err(link_err), .link_tx(link_tx), .link_flags(link_flags));
  lrd_peer lrd_peer_i (.clk(clk), .go(go), .data(pdata), .idx(pidx),
    .stn(2'h1), .link_rx(link_rx));
  // ==========================================
  // Nonvolatile store; flag frozen while power is off
  always @(posedge clk) begin
    nv_rdata <= nvm[nv_addr];
    if (nv_we) nvm[nv_addr] <= nv_wdata;
    up <= reset ? 0 : up + 1;
    if (!reset && up > 4) nvf <= nv_flag_out;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end
  // ==========================================
  // Helpers
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  function automatic logic [15:0] bcd(input int n);
    return 16'((n / 10) * 16 + n % 10);
  endfunction : bcd
  task automatic chk(input string s, input logic [15:0] e,
      input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
    @(posedge clk);
  endtask : rd
  task automatic send(input logic [2:0] i, input logic [15:0] d);
    pidx <= i;
    pdata <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (15) @(posedge clk);
  endtask : send
  task automatic scan(input int n);
    repeat (n) @(posedge clk);
    scan_end <= 1'b1;
    @(posedge clk);
    scan_end <= 1'b0;
  endtask : scan
  task automatic complete_run();
    $display("fails %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // ==========================================
  // Main sequence
  initial begin
    reset = 1'b1; ce = 1'b1; bus = '0; scan_end = 1'b0; go = 1'b0;
    prog_illegal = 1'b0; analog_timer_one_raw = 8'h00; analog_timer_two_raw = 8'h00;
    link_err = 4'h0; nvf = 1'b0; pidx = 3'h0; pdata = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      nvm[i] = xs();
      m[i] = nvm[i];
    end
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    wr(A_CONFIG, 16'h0002);
    for (int i = 0; i < 16; i++) begin
      w[i] = xs();
      wr(8'(8'h10 + i), w[i]);
      if (i < 12) m[i] = w[i];
    end
    wr(A_CMD, 16'h0001);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 16; i++) chk("saved word", m[i], nvm[i]);
    rd(A_RET_CTRL); chk("retained bit", 16'h8000, v & 16'h8000);
    // Power cycle with the flag kept
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (30) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      rd(8'(8'h10 + i)); chk("loaded word", m[i], v);
    end
    wr(A_CMD, 16'h0002);
    rd(8'h10); chk("cleared word", 16'h0000, v);
    rd(A_RET_CTRL); chk("retained bit", 16'h0000, v & 16'h8000);
    // Link at 128 bits; second peer word is a foreign index
    wr(A_CONFIG, 16'h0004);
    wr(8'h18, w[0]);
    send(3'h2, w[1]);
    send(3'h0, w[2]);
    rd(8'h1A); chk("peer word", w[1], v);
    rd(8'h18); chk("own word", w[0], v);
    #1;
    for (int k = 0; k < 20 && link_tx.idx !== 3'h0; k++) begin
      @(posedge clk);
      #1;
    end
    chk("sent word", w[0], link_tx.data);
    wr(A_CMD, 16'h0004);
    wr(A_CONFIG, 16'h0002);
    wr(A_CMD, 16'h0008);
    rd(A_STATUS); chk("late size xfer", 16'h0002, v & 16'h000A);
    wr(A_CMD, 16'h0010);
    prog_illegal <= 1'b1;
    wr(A_CMD, 16'h0004);
    wr(A_CMD, 16'h0008);
    rd(A_STATUS); chk("illegal xfer", 16'h0002, v & 16'h000A);
    prog_illegal <= 1'b0;
    link_err <= 4'h2;
    repeat (6) @(posedge clk);
    rd(A_LINK_FLAGS); chk("link flags", 16'h00D2, v & 16'h00FF);
    chk("flag pins", 16'h00D2, {8'h00, link_flags});
    // Scan lengths of about four and one steps
    scan(1);
    wr(A_CONFIG, 16'h0003);
    scan(40);
    scan(14);
    rd(A_SCAN); chk("scan word", 16'h0104, v);
    wr(A_CONFIG, 16'h0002);
    wr(A_CONFIG, 16'h0003);
    rd(A_SCAN); chk("max after start", 16'h0000, v & 16'h00FF);
    wr(A_CONFIG, 16'h0005);
    rd(A_CONFIG); chk("size in run", 16'h0003, v & 16'h0007);
    rd(A_STATUS); chk("size refused", 16'h0004, v & 16'h0004);
    for (int k = 0; k < 4; k++) begin
      x = int'(xs() % 16'h0078);
      analog_timer_one_raw <= 8'(x);
      analog_timer_two_raw <= 8'(119 - x);
      repeat (6) @(posedge clk);
      rd(A_ANALOG_TIMER_ONE); chk("timer one", bcd(x > 99 ? 99 : x), v);
      rd(A_ANALOG_TIMER_TWO); chk("timer two", bcd(x < 20 ? 99 : 119 - x), v);
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
